/* core/zac_checker.sv */
// zac_checker: access checker for read, write and spare-byte update commands.
// assumes an APB master on ref_clk_i; zone data is fetched and stored outside.
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
module zac_checker (
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic             pready_o,
   output logic [31:0]      prdata_o,
   output logic             pslverr_o,
   output logic             done_o,
   output logic [7:0]       status_o,
   output logic             zone_grant_o,
   output logic             zone_write_o,
   output logic             zone_block_o,
   output logic [1:0]       zone_sel_o,
   output logic [6:0]       zone_word_o,
   output logic [31:0]      zone_data_o
);
   zac_pkg::zac_state_t  r;       // current state
   zac_pkg::zac_state_t  n;       // next state
   logic [15:0]          pol_raw; // policy of the addressed slot
   zac_pkg::zac_policy_t pol;     // same, as fields

   // policy store; read address follows the command register
   zac_policy_mem u_pol (
      .ref_clk_i (ref_clk_i),
      .arst_n_i  (arst_n_i),
      .wr_i      (r.pol_wr),
      .raddr_i   (r.cmd.p2[6:3]),
      .rdata_o   (pol_raw)
   );
   assign pol = zac_pkg::zac_policy_t'(pol_raw);

   localparam int POL_HI = zac_pkg::POL_IDX_LO + 3;  // top of slot index field

   // bus slave, command sequencing and all permission checks
   always_comb begin
      logic [1:0]  zone;     // selected zone
      logic        big;      // 32-byte access
      logic        enc_in;   // host asks for encrypted input
      logic [6:0]  word;     // word address inside zone
      logic [6:0]  first;    // first word touched
      logic [6:0]  last;     // last word touched
      logic        bad_rng;  // address outside the zone
      logic        rkey_ok;  // scratch key fit for encrypted read
      logic        wkey_ok;  // scratch key fit for encrypted write
      logic [7:0]  code;     // answer code
      logic [31:0] res;      // word handed to the zone port
      zone    = r.cmd.p1[1:0];
      big     = r.cmd.p1[7];
      enc_in  = r.cmd.p1[6];
      word    = r.cmd.p2[6:0];
      first   = big ? {word[6:3], 3'h0} : word;
      last    = big ? {word[6:3], 3'h7} : word;
      bad_rng = |r.cmd.p2[15:7];
      case (zone)
         zac_pkg::ZONE_CFG: begin
            bad_rng = bad_rng | (last > zac_pkg::CFG_LAST);
         end
         zac_pkg::ZONE_OTP: begin
            bad_rng = bad_rng | (|word[6:4]);
         end
         default: begin
            bad_rng = bad_rng;
         end
      endcase
      rkey_ok = r.key.valid && r.key.gen && r.key.origin_rand
                && (r.key.src == pol.rd_key);
      wkey_ok = r.key.valid && r.key.gen && r.key.origin_rand
                && (r.key.src == pol.wr_key);
      code = zac_pkg::RC_OK;
      res  = r.fetch;
      n = r;
      n.pol_wr = '0;
      n.done   = 1'b0;
      n.grant  = 1'b0;
      n.wr     = 1'b0;
      n.pready = 1'b0;
      // access phase: answer one cycle after penable rises
      if (psel_i && penable_i && !r.pready) begin
         n.pready  = 1'b1;
         n.pslverr = 1'b0;
         n.prdata  = '0;
         if (pwrite_i) begin
            case (paddr_i)
               zac_pkg::REG_CMD: begin
                  // a command while busy is refused, not queued
                  if (r.fsm == zac_pkg::FSM_IDLE) begin
                     n.cmd = zac_pkg::zac_cmd_t'(pwdata_i);
                     n.fsm = zac_pkg::FSM_FETCH;
                  end else begin
                     n.pslverr = 1'b1;
                  end
               end
               zac_pkg::REG_LOCK:  n.lock  = zac_pkg::zac_lock_t'(pwdata_i[3:0]);
               zac_pkg::REG_KEYST: n.key   = zac_pkg::zac_key_t'(pwdata_i[6:0]);
               zac_pkg::REG_KEYW:  n.keyw  = pwdata_i;
               zac_pkg::REG_FETCH: n.fetch = pwdata_i;
               zac_pkg::REG_WDATA: n.wdata = pwdata_i;
               zac_pkg::REG_SPARE: begin
                  // spare bytes are owned by the checker while busy
                  if (r.fsm == zac_pkg::FSM_IDLE) begin
                     n.spare = zac_pkg::zac_spare_t'(pwdata_i[23:0]);
                  end else begin
                     n.pslverr = 1'b1;
                  end
               end
               zac_pkg::REG_POLICY: begin
                  n.pol_wr.en   = 1'b1;
                  n.pol_wr.idx  = pwdata_i[POL_HI:zac_pkg::POL_IDX_LO];
                  n.pol_wr.data = pwdata_i[15:0];
               end
               zac_pkg::REG_STATUS, zac_pkg::REG_RESULT: begin
                  n.pslverr = 1'b0;  // read-only, write ignored
               end
               default: n.pslverr = 1'b1;
            endcase
         end else begin
            case (paddr_i)
               zac_pkg::REG_CMD:    n.prdata = r.cmd;
               zac_pkg::REG_LOCK:   n.prdata = {28'h0000000, r.lock};
               zac_pkg::REG_KEYST:  n.prdata = {25'h0000000, r.key};
               zac_pkg::REG_KEYW:   n.prdata = r.keyw;
               zac_pkg::REG_FETCH:  n.prdata = r.fetch;
               zac_pkg::REG_WDATA:  n.prdata = r.wdata;
               zac_pkg::REG_SPARE:  n.prdata = {8'h00, r.spare};
               zac_pkg::REG_POLICY: n.prdata = 32'h00000000;
               zac_pkg::REG_STATUS: begin
                  n.prdata = {1'b0, r.word, r.status, 12'h000,
                              r.blk, r.wr, r.grant, r.fsm != zac_pkg::FSM_IDLE};
               end
               zac_pkg::REG_RESULT: n.prdata = r.result;
               default:             n.pslverr = 1'b1;
            endcase
         end
      end
      // command sequencing
      case (r.fsm)
         zac_pkg::FSM_FETCH: begin
            // policy read data for the new slot lands next cycle, in FSM_EVAL
            n.fsm = zac_pkg::FSM_EVAL;
         end
         zac_pkg::FSM_EVAL: begin
            case (r.cmd.op)
               zac_pkg::OP_READ: begin
                  if (zone == zac_pkg::ZONE_RSVD) begin
                     code = zac_pkg::RC_PARSE;
                  end else if (bad_rng) begin
                     code = zac_pkg::RC_EXEC;
                  end else if (zone == zac_pkg::ZONE_CFG) begin
                     if (last > zac_pkg::CFG_RD_MAX) begin
                        code = zac_pkg::RC_EXEC;
                     end
                  end else if (zone == zac_pkg::ZONE_OTP) begin
                     // read-only mode allows both sizes anywhere
                     if (!r.lock.data_locked) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (r.lock.otp_mode == zac_pkg::OTP_LEGACY
                                  && (big || word < zac_pkg::OTP_PROT)) begin
                        code = zac_pkg::RC_EXEC;
                     end
                  end else begin
                     if (!r.lock.data_locked) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (pol.secret && !pol.enc_rd) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (pol.secret && !big) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (pol.secret && !rkey_ok) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (pol.secret) begin
                        res = r.fetch ^ r.keyw;
                     end else begin
                        res = r.fetch;
                     end
                  end
               end
               zac_pkg::OP_WRITE: begin
                  res = enc_in ? (r.wdata ^ r.keyw) : r.wdata;
                  if (zone == zac_pkg::ZONE_RSVD) begin
                     code = zac_pkg::RC_PARSE;
                  end else if (bad_rng) begin
                     code = zac_pkg::RC_EXEC;
                  end else if (zone == zac_pkg::ZONE_CFG) begin
                     if (r.lock.cfg_locked || enc_in
                         || first < zac_pkg::CFG_WR_MIN
                         || last > zac_pkg::CFG_RD_MAX) begin
                        code = zac_pkg::RC_EXEC;
                     end
                  end else if (!r.lock.cfg_locked) begin
                     code = zac_pkg::RC_EXEC;
                  end else if (!r.lock.data_locked) begin
                     // open zones take only whole blocks; encrypted input also needs a valid, generated key
                     if (!big || (enc_in && !(r.key.valid && r.key.gen))) begin
                        code = zac_pkg::RC_EXEC;
                     end
                  end else if (zone == zac_pkg::ZONE_OTP) begin
                     if (r.lock.otp_mode != zac_pkg::OTP_CONSUM || enc_in) begin
                        code = zac_pkg::RC_EXEC;
                     end else begin
                        res = r.fetch & r.wdata;
                     end
                  end else begin
                     if (!big && (pol.secret
                                  || pol.wr_policy != zac_pkg::WP_ALWAYS)) begin
                        code = zac_pkg::RC_EXEC;
                     end else if (pol.wr_policy == zac_pkg::WP_ALWAYS) begin
                        res = r.wdata;
                     end else if (pol.wr_policy[2] && wkey_ok) begin
                        res = r.wdata ^ r.keyw;
                     end else begin
                        code = zac_pkg::RC_EXEC;
                     end
                  end
               end
               zac_pkg::OP_UPDATE: begin
                  if ((|r.cmd.p1[7:1]) || (|r.cmd.p2[15:8])) begin
                     code = zac_pkg::RC_PARSE;
                  end else if (!r.cmd.p1[0]) begin
                     if (r.spare.user != 8'h00) begin
                        code = zac_pkg::RC_EXEC;
                     end else begin
                        n.spare.user = r.cmd.p2[7:0];
                     end
                  end else if (r.spare.guard != 8'h00
                               && r.spare.selector != 8'h00) begin
                     code = zac_pkg::RC_EXEC;
                  end else begin
                     n.spare.selector = r.cmd.p2[7:0];
                  end
               end
               default: begin
                  code = zac_pkg::RC_PARSE;
               end
            endcase
            // failures hand out the code, block flag and word, but no data, grant or write
            n.status = code;
            n.grant  = (code == zac_pkg::RC_OK)
                       && (r.cmd.op != zac_pkg::OP_UPDATE);
            n.wr     = (code == zac_pkg::RC_OK)
                       && (r.cmd.op == zac_pkg::OP_WRITE);
            n.result = n.grant ? res : 32'h00000000;
            n.blk    = big;
            n.word   = first;
            n.done   = 1'b1;
            n.fsm    = zac_pkg::FSM_IDLE;
         end
         default: begin
            // idle keeps n.fsm as the bus block left it, so a command write starts
         end
      endcase
   end

   // single state register
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= zac_pkg::STATE_RST;
      end else begin
         r <= n;
      end
   end

   // every output is a field of the state register
   assign pready_o     = r.pready;
   assign prdata_o     = r.prdata;
   assign pslverr_o    = r.pslverr;
   assign done_o       = r.done;
   assign status_o     = r.status;
   assign zone_grant_o = r.grant;
   assign zone_write_o = r.wr;
   assign zone_block_o = r.blk;
   assign zone_sel_o   = r.cmd.p1[1:0];
   assign zone_word_o  = r.word;
   assign zone_data_o  = r.result;

   // checks on the checker
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic eval_c;  // evaluation cycle
   assign eval_c = (r.fsm == zac_pkg::FSM_EVAL);

   bus_answer_a: assert property (
      psel_i && penable_i && !r.pready |=> r.pready)
      else $error("access phase got no answer");

   cmd_flow_a: assert property (
      r.fsm == zac_pkg::FSM_FETCH |=> eval_c ##1 (r.done && r.fsm == zac_pkg::FSM_IDLE))
      else $error("command did not finish in two cycles");

   deny_clean_a: assert property (
      r.done && r.status != zac_pkg::RC_OK |-> r.result == 32'h0 && !r.grant && !r.wr)
      else $error("failed command leaked data or access");

   zone_rsvd_a: assert property (
      eval_c && r.cmd.p1[1:0] == zac_pkg::ZONE_RSVD
      && (r.cmd.op == zac_pkg::OP_READ || r.cmd.op == zac_pkg::OP_WRITE)
      |=> r.status == zac_pkg::RC_PARSE)
      else $error("reserved zone not refused");

   secret_read_a: assert property (
      eval_c && r.cmd.op == zac_pkg::OP_READ && r.cmd.p1[1:0] == zac_pkg::ZONE_DATA
      && pol.secret && !pol.enc_rd |=> r.status != zac_pkg::RC_OK && !r.grant)
      else $error("secret slot was read");

   enc_xor_a: assert property (
      (eval_c && r.cmd.op == zac_pkg::OP_READ && r.cmd.p1[1:0] == zac_pkg::ZONE_DATA
       && pol.secret) ##1 r.grant |-> r.result == ($past(r.fetch) ^ $past(r.keyw)))
      else $error("encrypted read not keyed");

   user_once_a: assert property (
      eval_c && r.cmd.op == zac_pkg::OP_UPDATE && r.cmd.p1 == 8'h00
      && r.cmd.p2[15:8] == 8'h00 && r.spare.user != 8'h00
      |=> r.status == zac_pkg::RC_EXEC && $stable(r.spare.user))
      else $error("user spare byte rewritten");

   guard_free_a: assert property (
      eval_c && r.cmd.op == zac_pkg::OP_UPDATE && r.cmd.p1 == 8'h01
      && r.cmd.p2[15:8] == 8'h00 && r.spare.guard == 8'h00
      |=> r.status == zac_pkg::RC_OK && r.spare.selector == $past(r.cmd.p2[7:0]))
      else $error("unguarded selector not overwritten");

   cfg_open_a: assert property (
      eval_c && r.cmd.op == zac_pkg::OP_WRITE && !r.lock.cfg_locked
      && r.cmd.p1[1:0] != zac_pkg::ZONE_CFG |=> !r.wr && r.status != zac_pkg::RC_OK)
      else $error("write passed with config open");

   short_wr_a: assert property (
      eval_c && r.cmd.op == zac_pkg::OP_WRITE && !r.cmd.p1[7]
      && !r.lock.data_locked && r.cmd.p1[1:0] != zac_pkg::ZONE_CFG |=> !r.wr)
      else $error("short write before lock");

   enc_read_c: cover property (
      eval_c && r.cmd.op == zac_pkg::OP_READ && pol.secret ##1 r.grant);
   update_c: cover property (
      eval_c && r.cmd.op == zac_pkg::OP_UPDATE ##1 r.status == zac_pkg::RC_OK);
   consume_c: cover property (
      eval_c && r.cmd.p1[1:0] == zac_pkg::ZONE_OTP && r.lock.data_locked ##1 r.wr);
   parse_c: cover property (r.done && r.status == zac_pkg::RC_PARSE);
endmodule

/* core/zac_pkg.sv */
// zac_pkg: register map, field layouts, codes and reset values
// for the zone access checker.
// assumes a single 250 MHz clock domain and an APB master with 32-bit data.
package zac_pkg;
   // register byte offsets on APB
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_LOCK   = 8'h04;
   localparam logic [7:0] REG_KEYST  = 8'h08;
   localparam logic [7:0] REG_KEYW   = 8'h0C;
   localparam logic [7:0] REG_FETCH  = 8'h10;
   localparam logic [7:0] REG_WDATA  = 8'h14;
   localparam logic [7:0] REG_SPARE  = 8'h18;
   localparam logic [7:0] REG_POLICY = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_RESULT = 8'h24;
   // command opcodes
   localparam logic [7:0] OP_READ    = 8'h02;
   localparam logic [7:0] OP_WRITE   = 8'h12;
   localparam logic [7:0] OP_UPDATE  = 8'h20;
   // zone select codes
   localparam logic [1:0] ZONE_CFG   = 2'h0;
   localparam logic [1:0] ZONE_OTP   = 2'h1;
   localparam logic [1:0] ZONE_DATA  = 2'h2;
   localparam logic [1:0] ZONE_RSVD  = 2'h3;
   // answer codes
   localparam logic [7:0] RC_OK      = 8'h00;
   localparam logic [7:0] RC_PARSE   = 8'h03;
   localparam logic [7:0] RC_EXEC    = 8'h0F;
   // one-time zone policy modes
   localparam logic [1:0] OTP_RDONLY = 2'h0;
   localparam logic [1:0] OTP_CONSUM = 2'h1;
   localparam logic [1:0] OTP_LEGACY = 2'h2;
   // write policy value meaning always writable in clear
   localparam logic [3:0] WP_ALWAYS  = 4'h0;
   // word limits inside zones
   localparam logic [6:0] CFG_LAST   = 7'h15;
   localparam logic [6:0] CFG_RD_MAX = 7'h0F;
   localparam logic [6:0] CFG_WR_MIN = 7'h04;
   localparam logic [6:0] OTP_PROT   = 7'h02;
   // policy write field position inside REG_POLICY
   localparam int         POL_IDX_LO = 16;

   typedef enum logic [1:0] {
      FSM_IDLE  = 2'b00,
      FSM_FETCH = 2'b01,
      FSM_EVAL  = 2'b10
   } zac_fsm_t;

   typedef struct packed {
      logic [15:0] p2;         // second_parameter
      logic [7:0]  p1;         // first_parameter
      logic [7:0]  op;
   } zac_cmd_t;

   // slot_policy_word; bit 14 is wr_policy[2]
   typedef struct packed {
      logic [3:0] wr_policy;   // write_policy_field
      logic [3:0] wr_key;
      logic       secret;      // secret_slot_flag
      logic       enc_rd;      // encrypted_read_flag
      logic [1:0] rsvd;
      logic [3:0] rd_key;      // read_key_slot
   } zac_policy_t;

   // scratch_key_register status
   typedef struct packed {
      logic       origin_rand; // key_origin_flag
      logic [3:0] src;         // key_source_slot
      logic       gen;         // digest_generated_flag
      logic       valid;
   } zac_key_t;

   typedef struct packed {
      logic [1:0] otp_mode;    // otp_policy_mode
      logic       data_locked;
      logic       cfg_locked;
   } zac_lock_t;

   typedef struct packed {
      logic [7:0] selector;    // config byte 85
      logic [7:0] user;        // user_spare_byte, config byte 84
      logic [7:0] guard;       // selector_guard_mode, config byte 19
   } zac_spare_t;

   typedef struct packed {
      logic        en;
      logic [3:0]  idx;
      logic [15:0] data;
   } zac_pol_wr_t;

   typedef struct packed {
      zac_fsm_t    fsm;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      zac_cmd_t    cmd;
      zac_lock_t   lock;
      zac_key_t    key;
      logic [31:0] keyw;
      logic [31:0] fetch;
      logic [31:0] wdata;
      zac_spare_t  spare;
      zac_pol_wr_t pol_wr;
      logic [7:0]  status;
      logic [31:0] result;
      logic        grant;
      logic        wr;
      logic        blk;
      logic [6:0]  word;
      logic        done;
   } zac_state_t;

   localparam zac_state_t STATE_RST = '0;
endpackage

/* core/zac_policy_mem.sv */
// zac_policy_mem: sixteen slot policy words with a registered read port.
// assumes one writer and that the reader waits one cycle for data.
`timescale 1ns/100ps
module zac_policy_mem (
   input  wire logic                ref_clk_i,
   input  wire logic                arst_n_i,
   input  wire zac_pkg::zac_pol_wr_t wr_i,
   input  wire logic [3:0]          raddr_i,
   output logic [15:0]              rdata_o
);
   typedef struct packed {
      logic [15:0][15:0] words;  // one policy per slot
      logic [15:0]       rdata;  // read data register
   } zac_mem_state_t;

   zac_mem_state_t r;            // current state
   zac_mem_state_t n;            // next state

   // read first, then write, so the read register samples the old array value
   always_comb begin
      n = r;
      n.rdata = r.words[raddr_i];
      if (wr_i.en) begin
         n.words[wr_i.idx] = wr_i.data;
      end
   end

   // policies clear to zero so slots start plain and open
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign rdata_o = r.rdata;
endmodule

/* dv/testbench.sv */
// testbench: drives the checker over apb and scores each command answer.
// assumes zone words are staged in fetch/wdata before every command.
`timescale 1ns/100ps
module testbench;
   logic        ref_clk_i = 1'b0, arst_n_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0]  pa = 8'h00, st;
   logic [31:0] pwd = 32'h0, fw, kw, wd, mw, prd, zd;
   logic [32:0] rsp;                   // {pslverr, prdata} of last transfer
   logic [40:0] cur, exp_q[$];         // {skip data, code, data}
   logic [6:0]  wo;
   logic [1:0]  zs;
   logic        rdy, err, dn, gr, zw, zb;
   int          num_errors = 0, check_count = 0;
   integer      seed = 32'he70826b8;
   always #2 ref_clk_i = ~ref_clk_i;
   zac_checker u_zac_checker (.ref_clk_i, .arst_n_i, .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .pready_o(rdy), .prdata_o(prd),
      .pslverr_o(err), .done_o(dn), .status_o(st), .zone_grant_o(gr), .zone_write_o(zw),
      .zone_block_o(zb), .zone_sel_o(zs), .zone_word_o(wo), .zone_data_o(zd));
   zac_zone_model u_zac_zone_model (.ref_clk_i, .arst_n_i, .grant_i(gr), .write_i(zw),
      .data_i(zd), .word_o(mw));
   task automatic check(input logic [39:0] seen, input logic [39:0] want);
      check_count++;
      if (seen !== want) begin
         num_errors++;
         $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // one apb transfer; request held until pready is sampled high, or for at most 20 cycles
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      {psel, pwr, pa, pwd, pen} <= {1'b1, w, a, d, 1'b0};
      @(posedge ref_clk_i);
      pen <= 1'b1;
      do @(posedge ref_clk_i); while (rdy !== 1'b1 && ++n < 20);
      if (rdy !== 1'b1) num_errors++;  // bus answer never came
      rsp = {err, prd};
      {psel, pen} <= 2'b00;
   endtask
   // note the answer, start the command, wait a bounded time for done
   task automatic cmd(input logic [31:0] c, input logic [40:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      apb(1'b1, zac_pkg::REG_CMD, c);
      do @(posedge ref_clk_i); while (dn !== 1'b1 && ++n < 8);
      if (dn !== 1'b1) num_errors++;  // command never finished
   endtask
   // scorer: failed commands must show zero data, so data is compared too unless the skip data bit is set
   always @(posedge ref_clk_i) begin
      if (dn === 1'b1 && exp_q.size() > 0) begin
         cur = exp_q.pop_front();
         check({st, cur[40] ? cur[31:0] : zd}, cur[39:0]);
      end
   end
   initial begin
      repeat (16) @(posedge ref_clk_i);
      arst_n_i <= 1'b1;
      fw = $random(seed);
      kw = $random(seed);
      wd = $random(seed);
      apb(1'b1, zac_pkg::REG_FETCH, fw);
      cmd({16'h0018, 8'h02, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0018, 8'h02, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      apb(1'b1, zac_pkg::REG_LOCK, 32'h3);
      apb(1'b1, zac_pkg::REG_POLICY, 32'h0003_0000);
      apb(1'b1, zac_pkg::REG_POLICY, 32'h0005_0080);
      apb(1'b1, zac_pkg::REG_POLICY, 32'h0006_00C6);
      apb(1'b1, zac_pkg::REG_KEYW, kw);
      apb(1'b1, zac_pkg::REG_WDATA, wd);
      apb(1'b1, zac_pkg::REG_KEYST, 32'h5B);
      cmd({16'h0019, 8'h02, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_OK, fw});
      cmd({16'h001F, 8'h82, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_OK, fw});
      check({30'h0, zs, zb, wo}, {30'h0, zac_pkg::ZONE_DATA, 1'b1, 7'h18});
      cmd({16'h001A, 8'h02, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_OK, wd});
      @(posedge ref_clk_i);
      check({8'h00, mw}, {8'h00, wd});
      cmd({16'h0028, 8'h82, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0030, 8'h82, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_OK, fw ^ kw});
      cmd({16'h0030, 8'h02, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0030, 8'h02, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      apb(1'b1, zac_pkg::REG_KEYST, 32'h57);
      cmd({16'h0030, 8'h82, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      apb(1'b1, zac_pkg::REG_POLICY, 32'h0007_4500);
      cmd({16'h0038, 8'h82, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_OK, wd ^ kw});
      cmd({16'h0018, 8'h03, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_PARSE, 32'h0});
      cmd({16'h0118, 8'h02, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0005, 8'h00, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0008, 8'h81, zac_pkg::OP_READ}, {1'b0, zac_pkg::RC_OK, fw});
      cmd({16'h000B, 8'h01, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_EXEC, 32'h0});
      apb(1'b1, zac_pkg::REG_LOCK, 32'h7);
      cmd({16'h000B, 8'h01, zac_pkg::OP_WRITE}, {1'b0, zac_pkg::RC_OK, fw & wd});
      cmd({16'h00A5, 8'h00, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_OK, 32'h0});
      cmd({16'h005A, 8'h00, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_EXEC, 32'h0});
      cmd({16'h0011, 8'h01, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_OK, 32'h0});
      cmd({16'h0077, 8'h01, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_OK, 32'h0});
      apb(1'b0, zac_pkg::REG_SPARE, 32'h0);
      check({7'h00, rsp}, {8'h00, 32'h0077_A500});
      apb(1'b1, zac_pkg::REG_SPARE, 32'h1);
      cmd({16'h003C, 8'h01, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_OK, 32'h0});
      cmd({16'h0044, 8'h01, zac_pkg::OP_UPDATE}, {1'b1, zac_pkg::RC_EXEC, 32'h0});
      apb(1'b0, zac_pkg::REG_SPARE, 32'h0);
      check({7'h00, rsp}, {8'h00, 32'h003C_0001});
      apb(1'b0, 8'h40, 32'h0);
      check({7'h00, rsp}, {8'h01, 32'h0});
      repeat (4) @(posedge ref_clk_i);
      conclude();
   end
   // watchdog: the whole sequence needs a few hundred cycles at most
   initial begin
      #100000;
      num_errors++;
      conclude();
   end
endmodule

/* dv/zac_zone_model.sv */
// zac_zone_model: stand-in for the zone store behind the checker.
// assumes granted stores arrive as one-cycle pulses with their word.
`timescale 1ns/100ps
module zac_zone_model (
   input  wire logic        ref_clk_i,
   input  wire logic        arst_n_i,
   input  wire logic        grant_i,   // access permitted
   input  wire logic        write_i,   // access is a store
   input  wire logic [31:0] data_i,    // word to store
   output logic [31:0]      word_o     // last stored word
);
   // refused stores must leave the array alone, so only grants land
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         word_o <= 32'h0000_0000;
      end else if (grant_i && write_i) begin
         word_o <= data_i;
      end
   end
endmodule
